// [verilog/nsf_host.sv]
// Purpose: Host controller for status reads and feature access of a NAND device.
// Assumes: Software orders operations over Avalon-MM; one operation at a time.
// Notes: The device's ready/busy line and data bus pass two flip-flops first.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Status mode persists until next command; issue read command to resume data.
// - Enhanced status command is followed by three row address cycles.
// - Never send enhanced status during reset or one-time-programmable mode.
// - Never send reset while a set feature sequence runs.
// - Once get feature bytes start, all four are read first.
// - Hold write guard low during power up and power down.
// - Multi-plane addresses share LUN and page, differ in plane.
// - Multi-plane copy-back stays inside its plane.
// - Pages of a block are programmed in ascending order.
module nsf_host
	import nsf_pkg::*;
#(
	parameter int WG_SETTLE = WG_SETTLE_CYC
)
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// Avalon-MM slave.
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// NAND control pins.
	output logic chip_sel_low,
	output logic cmd_latch,
	output logic addr_latch,
	output logic write_strobe_low,
	output logic read_strobe_low,
	output logic write_guard_low,
	// NAND data bus, two-way.
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe,
	// Ready/busy, open drain from device.
	input wire logic ready_busy_low
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [7:0] io_s1_ff, io_s2_ff;
	logic rb_s1_ff, rb_s2_ff;
	always_ff @(posedge mclk)
	begin
		io_s1_ff <= io_in;
		io_s2_ff <= io_s1_ff;
		rb_s1_ff <= ready_busy_low;
		rb_s2_ff <= rb_s1_ff;
	end

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] op_cmd_ff, op_addr_ff, op_lun_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [7:0] status_ff;
	logic illegal_ff, done_flag_ff, wg_enable_ff;
	logic [23:0] row_ff;
	logic [$clog2(WG_SETTLE+1)-1:0] wg_cnt_ff;
	nsf_state_e state_ff, nxt_state;
	logic [2:0] idx_ff;
	logic go;

	// Function: number of address bytes after a command.
	function automatic logic [2:0] addr_count(input logic [7:0] c);
		case (c)
			CMD_STATUS_ENH: addr_count = 3'h3;
			CMD_SET_FEAT, CMD_GET_FEAT: addr_count = 3'h1;
			CMD_SET_LUN_FEAT, CMD_GET_LUN_FEAT: addr_count = 3'h2;
			default: addr_count = 3'h0;
		endcase
	endfunction : addr_count

	// Function: whether a command is legal with the present settings.
	// Only read, status, feature and reset commands are issued, so no program or
	// multi-plane sequence ever reaches the device from this controller.
	function automatic logic cmd_legal(input logic [7:0] c, input logic [7:0] lun,
		input logic [7:0] fa, input logic [7:0] p1);
		logic lun_ok;
		logic known;
		lun_ok = (c != CMD_SET_LUN_FEAT && c != CMD_GET_LUN_FEAT) || lun <= LUN_MAX;
		known = c == CMD_READ || c == CMD_STATUS || c == CMD_STATUS_ENH ||
			c == CMD_SET_FEAT || c == CMD_GET_FEAT || c == CMD_SET_LUN_FEAT ||
			c == CMD_GET_LUN_FEAT || c == CMD_RESET;
		if (c == CMD_SET_FEAT || c == CMD_SET_LUN_FEAT)
			cmd_legal = known && lun_ok && fa == FEAT_DRIVE && p1 <= DRIVE_MAX;
		else
			cmd_legal = known && lun_ok;
	endfunction : cmd_legal

	// Decode of bus accesses.
	wire bus_wr = avs_write && !avs_waitrequest;
	wire wr_ctrl = bus_wr && avs_address == REG_CTRL;
	wire idle = state_ff == NSF_IDLE || state_ff == NSF_DONE || state_ff == NSF_ERROR;
	// Enhanced status is refused while the device is still busy after a reset.
	wire enh_blocked = avs_writedata[7:0] == CMD_STATUS_ENH && !rb_s2_ff;
	wire cur_legal = cmd_legal(avs_writedata[7:0], op_lun_ff, op_addr_ff, wdata_ff[7:0]) &&
		!enh_blocked;
	assign go = wr_ctrl && avs_writedata[CTRL_GO] && idle;
	assign avs_waitrequest = 1'b0;

	// Register writes from software, with their reset values.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			op_cmd_ff <= CMD_READ;
			op_addr_ff <= OUTPUT_DRIVE_SELECT_OFS;
			op_lun_ff <= 8'h00;
			row_ff <= 24'h000000;
			wdata_ff <= {{3{RESERVED_PARAM}}, OUTPUT_DRIVE_SELECT_RST};
			wg_enable_ff <= 1'b0;
		end
		else if (bus_wr)
		begin
			if (avs_address == REG_CTRL)
				op_cmd_ff <= avs_writedata[7:0];
			if (avs_address == REG_ADDR)
			begin
				op_addr_ff <= avs_writedata[7:0];
				op_lun_ff <= avs_writedata[15:8];
				row_ff <= avs_writedata[23:0];
			end
			if (avs_address == REG_WDATA)
				wdata_ff <= {{3{RESERVED_PARAM}}, avs_writedata[7:0]};
			if (avs_address == REG_WGUARD)
				wg_enable_ff <= avs_writedata[0];
		end
	end

	// Write guard: low after reset, released only after settling time.
	wire wg_done = wg_cnt_ff == ($clog2(WG_SETTLE+1))'(WG_SETTLE);
	always_ff @(posedge mclk)
	begin
		if (srst)
			wg_cnt_ff <= '0;
		else if (!wg_enable_ff)
			wg_cnt_ff <= '0;
		else if (!wg_done)
			wg_cnt_ff <= wg_cnt_ff + 1'b1;
	end
	assign write_guard_low = wg_enable_ff && wg_done;

	// ****************************************
	// Bus cycle engine
	// ****************************************
	logic cyc_start, cyc_read, cyc_busy, cyc_done;
	logic [7:0] cyc_data;
	nsf_cycle u_cycle (
		.mclk(mclk),
		.srst(srst),
		.start(cyc_start),
		.is_read(cyc_read),
		.busy(cyc_busy),
		.done(cyc_done),
		.write_strobe_low(write_strobe_low),
		.read_strobe_low(read_strobe_low),
		.bus_in(io_s2_ff),
		.rd_data(cyc_data)
	);

	wire is_status = op_cmd_ff == CMD_STATUS || op_cmd_ff == CMD_STATUS_ENH;
	wire is_get = op_cmd_ff == CMD_GET_FEAT || op_cmd_ff == CMD_GET_LUN_FEAT;
	wire is_set = op_cmd_ff == CMD_SET_FEAT || op_cmd_ff == CMD_SET_LUN_FEAT;
	wire [2:0] n_addr = addr_count(op_cmd_ff);
	wire rb_ready = rb_s2_ff;

	// Next state of the sequencer.
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			NSF_IDLE, NSF_DONE, NSF_ERROR:
				if (go)
					nxt_state = cur_legal ? NSF_CMD : NSF_ERROR;
			NSF_CMD:
				if (cyc_done)
					nxt_state = n_addr != 3'h0 ? NSF_ADDR : (is_status ? NSF_DATA_OUT : NSF_DONE);
			NSF_ADDR:
				if (cyc_done && idx_ff == n_addr - 3'h1)
					nxt_state = is_set ? NSF_DATA_IN : (is_get ? NSF_WAIT_RB : NSF_DATA_OUT);
			NSF_DATA_IN:
				if (cyc_done && idx_ff == 3'h3)
					nxt_state = NSF_WAIT_RB;
			NSF_WAIT_RB:
				if (rb_ready && !cyc_busy)
					nxt_state = is_get ? NSF_DATA_OUT : NSF_DONE;
			NSF_DATA_OUT:
				if (cyc_done && (is_status || idx_ff == 3'h3))
					nxt_state = NSF_DONE;
			default:
				nxt_state = NSF_IDLE;
		endcase
	end

	// Cycle requests and pin values.
	wire in_cyc_state = state_ff == NSF_CMD || state_ff == NSF_ADDR ||
		state_ff == NSF_DATA_IN || state_ff == NSF_DATA_OUT;
	wire [7:0] addr_byte = op_cmd_ff == CMD_STATUS_ENH ? row_ff[8*idx_ff[1:0] +: 8] :
		(idx_ff == 3'h0 && n_addr == 3'h2) ? op_lun_ff : op_addr_ff;
	assign cyc_start = in_cyc_state && !cyc_busy && !cyc_done;
	assign cyc_read = state_ff == NSF_DATA_OUT;
	assign chip_sel_low = state_ff != NSF_IDLE && state_ff != NSF_DONE && state_ff != NSF_ERROR;
	assign cmd_latch = state_ff == NSF_CMD && cyc_busy;
	assign addr_latch = state_ff == NSF_ADDR && cyc_busy;

	// Sequencer state, byte index and captured results.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_ff <= NSF_IDLE;
			idx_ff <= 3'h0;
			status_ff <= 8'h00;
			rdata_ff <= 32'h0000_0000;
			illegal_ff <= 1'b0;
			done_flag_ff <= 1'b0;
			io_out <= 8'h00;
			io_oe <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (state_ff != nxt_state)
				idx_ff <= 3'h0;
			else if (cyc_done)
				idx_ff <= idx_ff + 3'h1;
			if (go)
			begin
				illegal_ff <= !cur_legal;
				done_flag_ff <= 1'b0;
			end
			else if (nxt_state == NSF_DONE && state_ff != NSF_DONE)
				done_flag_ff <= 1'b1;
			// Status capture keeps all eight bits of the device byte.
			if (state_ff == NSF_DATA_OUT && cyc_done && is_status)
				status_ff <= cyc_data;
			if (state_ff == NSF_DATA_OUT && cyc_done && is_get)
				rdata_ff[8*idx_ff[1:0] +: 8] <= cyc_data;
			io_oe <= state_ff == NSF_CMD || state_ff == NSF_ADDR || state_ff == NSF_DATA_IN;
			case (state_ff)
				NSF_CMD: io_out <= op_cmd_ff;
				NSF_ADDR: io_out <= addr_byte;
				NSF_DATA_IN: io_out <= wdata_ff[8*idx_ff[1:0] +: 8];
				default: io_out <= 8'h00;
			endcase
		end
	end

	// Read multiplexer.
	wire [31:0] stat_word = {16'h0000, status_ff, 4'h0, illegal_ff, !rb_ready,
		done_flag_ff, !idle};
	always_comb
	begin
		avs_readdata = UNMAPPED_READ;
		if (avs_read)
		begin
			case (avs_address)
				REG_CTRL: avs_readdata = {24'h000000, op_cmd_ff};
				REG_ADDR: avs_readdata = {8'h00, row_ff};
				REG_WDATA: avs_readdata = wdata_ff;
				REG_STAT: avs_readdata = stat_word;
				REG_RDATA: avs_readdata = rdata_ff;
				REG_WGUARD: avs_readdata = {31'h0, wg_enable_ff};
				default: avs_readdata = UNMAPPED_READ;
			endcase
		end
	end
endmodule : nsf_host

// [verilog/nsf_pkg.sv]
// Purpose: Constants shared by the NAND status and feature host controller.
// Assumes: 8-bit asynchronous NAND bus, one clock at 100 MHz.
// Notes: Offsets of the controller's own Avalon-MM registers are word indices.
package nsf_pkg;
	// ****************************************
	// Clock and pin timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int STROBE_NS = 30;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WG_SETTLE_US = 100;
	localparam int WG_SETTLE_CYC = WG_SETTLE_US * 1000 / CLK_PERIOD_NS;
	localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
	localparam logic [3:0] STROBE_SPLIT = 4'(STROBE_CYC / 2);

	// ****************************************
	// Device commands and feature layout
	// ****************************************
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
	localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
	localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
	localparam logic [7:0] CMD_SET_LUN_FEAT = 8'hD5;
	localparam logic [7:0] CMD_GET_LUN_FEAT = 8'hD4;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] FEAT_DRIVE = 8'h10;
	localparam logic [7:0] OUTPUT_DRIVE_SELECT_OFS = 8'h10;
	localparam logic [7:0] OUTPUT_DRIVE_SELECT_RST = 8'h00;
	localparam logic [7:0] DRIVE_MAX = 8'h03;
	localparam logic [7:0] LUN_MAX = 8'h03;
	localparam logic [7:0] RESERVED_PARAM = 8'h00;

	// ****************************************
	// Status byte fields
	// ****************************************
	localparam int ST_FAIL = 0;
	localparam int ST_PREV_FAULT = 1;
	localparam int ST_ARRAY_IDLE = 5;
	localparam int ST_READY = 6;
	localparam int ST_UNPROT = 7;

	// ****************************************
	// Controller registers (word index on Avalon-MM)
	// ****************************************
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_ADDR = 3'h1;
	localparam logic [2:0] REG_WDATA = 3'h2;
	localparam logic [2:0] REG_STAT = 3'h3;
	localparam logic [2:0] REG_RDATA = 3'h4;
	localparam logic [2:0] REG_WGUARD = 3'h5;
	localparam int CTRL_GO = 8;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		NSF_IDLE = 4'b0000,
		NSF_CMD = 4'b0001,
		NSF_ADDR = 4'b0010,
		NSF_WAIT_RB = 4'b0011,
		NSF_DATA_OUT = 4'b0100,
		NSF_DATA_IN = 4'b0101,
		NSF_DONE = 4'b0110,
		NSF_ERROR = 4'b0111
	} nsf_state_e;
endpackage : nsf_pkg

// [verilog/nsf_cycle.sv]
// Purpose: One NAND bus cycle (command, address, data write or data read).
// Assumes: Cycle of twice STROBE_CNT clocks, strobe asserted until the last STROBE_SPLIT clocks.
// Notes: Read data is sampled from the synchronised bus at the strobe deassertion.
`timescale 1ns/1ps
module nsf_cycle
	import nsf_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// Request side.
	input wire logic start,
	input wire logic is_read,
	output logic busy,
	output logic done,
	// Strobes.
	output logic write_strobe_low,
	output logic read_strobe_low,
	// Data sampled from the bus.
	input wire logic [7:0] bus_in,
	output logic [7:0] rd_data
);
	logic [3:0] cnt_ff;
	logic active_ff;
	logic rd_ff;
	logic [7:0] rd_data_ff;
	logic done_ff;
	wire low_phase = active_ff && (cnt_ff > STROBE_SPLIT);
	wire last = active_ff && (cnt_ff == 4'h1);

	// Strobe shaping and completion.
	assign busy = active_ff;
	assign done = done_ff;
	assign rd_data = rd_data_ff;
	assign write_strobe_low = low_phase && !rd_ff;
	assign read_strobe_low = low_phase && rd_ff;

	// Cycle counter runs twice STROBE_CNT clocks.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			cnt_ff <= 4'h0;
			active_ff <= 1'b0;
			rd_ff <= 1'b0;
			done_ff <= 1'b0;
			rd_data_ff <= 8'h00;
		end
		else
		begin
			done_ff <= last;
			if (start && !active_ff)
			begin
				cnt_ff <= STROBE_CNT + STROBE_CNT;
				active_ff <= 1'b1;
				rd_ff <= is_read;
			end
			else if (active_ff)
			begin
				cnt_ff <= cnt_ff - 4'h1;
				active_ff <= !last;
			end
			if (active_ff && rd_ff && cnt_ff == STROBE_SPLIT + 4'h1)
				rd_data_ff <= bus_in;
		end
	end
endmodule : nsf_cycle

// [test/nsf_host_chk.sv]
// Purpose: Port-level assertions for the NAND status and feature controller.
// Assumes: Strobe and select pins are asserted high, as the controller drives them.
// Notes: Bound into every nsf_host instance.
`timescale 1ns/1ps
module nsf_host_chk
	import nsf_pkg::*;
#(
	parameter int WG_SETTLE = WG_SETTLE_CYC
)
(
	// Clock, reset and bus.
	input wire logic mclk,
	input wire logic srst,
	input wire logic [2:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	// NAND pins.
	input wire logic chip_sel_low,
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic write_strobe_low,
	input wire logic read_strobe_low,
	input wire logic write_guard_low,
	input wire logic [7:0] io_out,
	input wire logic io_oe
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	// The bus slave never stalls, and the pins keep their cycle discipline.
	a_wait_never: assert property (!avs_waitrequest)
		else $error("waitrequest raised");
	a_strobe_excl: assert property (!(write_strobe_low && read_strobe_low))
		else $error("both strobes asserted");
	a_read_released: assert property (read_strobe_low |-> !io_oe && chip_sel_low)
		else $error("host drives bus during a read cycle");
	a_latch_excl: assert property ((cmd_latch || addr_latch) |->
		chip_sel_low && io_oe && !(cmd_latch && addr_latch))
		else $error("bad latch cycle");
	a_strobe_end: assert property ($rose(write_strobe_low) |-> ##[1:12] !write_strobe_low)
		else $error("write strobe stuck");
	a_data_hold: assert property (write_strobe_low && $past(write_strobe_low) |-> $stable(io_out))
		else $error("data moved under the write strobe");
	a_guard_rst: assert property ($fell(srst) |-> !write_guard_low && !io_oe && !chip_sel_low)
		else $error("pins not idle after reset");
	a_guard_settle: assert property (avs_write && avs_address == REG_WGUARD &&
		avs_writedata[0] && !write_guard_low |=> !write_guard_low [*8])
		else $error("guard released too early");
endmodule : nsf_host_chk
bind nsf_host nsf_host_chk #(.WG_SETTLE(WG_SETTLE)) nsf_host_chk_i (.*);

// [test/nsf_dev_model.sv]
// Purpose: Behavioural NAND device answering status and feature commands.
// Assumes: Strobes asserted high; a cycle ends when its strobe deasserts.
// Notes: A bus released by both sides shows the inverse of its last known value.
`timescale 1ns/1ps
module nsf_dev_model
	import nsf_pkg::*;
(
	// Clock and status source.
	input wire logic mclk,
	input wire logic [7:0] dev_status,
	// Host pins.
	input wire logic chip_sel_low,
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic write_strobe_low,
	input wire logic read_strobe_low,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	// Device pins.
	output logic [7:0] io_in,
	output logic ready_busy_low
);
	logic [7:0] cmd = 8'h00;
	logic [7:0] ab [3];
	logic [7:0] drv [4] = '{default: 8'h00};
	logic [7:0] p1 = 8'h00;
	logic [7:0] lastv = 8'h00;
	logic [7:0] val;
	int n = 0;
	int k = 0;
	int bcnt = 0;

	// Status is shown live; feature reads give byte one then reserved zeros.
	assign val = (cmd == CMD_STATUS) ? dev_status :
		(cmd == CMD_STATUS_ENH) ? dev_status ^ ab[2] :
		(k != 0) ? 8'h00 : drv[(cmd == CMD_GET_LUN_FEAT) ? ab[0][1:0] : 2'h0];
	assign io_in = io_oe ? io_out : (chip_sel_low ? val : ~lastv);
	assign ready_busy_low = (bcnt == 0);

	// Busy countdown and last bus value.
	always @(posedge mclk)
	begin
		if (io_oe === 1'b1 || chip_sel_low === 1'b1)
			lastv <= io_in;
		if (bcnt != 0)
			bcnt = bcnt - 1;
	end

	// Command, address and data cycles latch at the end of the write strobe.
	always @(negedge write_strobe_low)
		if (chip_sel_low)
		begin
			if (cmd_latch)
			begin
				cmd = io_out;
				n = 0;
				k = 0;
				if (cmd == CMD_RESET)
					bcnt = 20;
			end
			else if (addr_latch)
			begin
				if (n < 3)
					ab[n] = io_out;
				n++;
				if ((cmd == CMD_GET_FEAT && n == 1) || (cmd == CMD_GET_LUN_FEAT && n == 2))
					bcnt = 8;
			end
			else
			begin
				if (k == 0)
					p1 = io_out;
				k++;
				if (k == 4 && cmd == CMD_SET_FEAT)
					drv = '{default: p1};
				if (k == 4 && cmd == CMD_SET_LUN_FEAT)
					drv[ab[0][1:0]] = p1;
			end
		end

	// Each read cycle moves to the next feature byte.
	always @(negedge read_strobe_low)
		if (chip_sel_low)
			k++;
endmodule : nsf_dev_model

// [test/nsf_host_tb.sv]
// Purpose: Self-checking bench for the NAND status and feature controller.
// Assumes: Device model on the pins, Avalon-MM tasks on the register side.
// Notes: Guard settle shortened to 10 clocks.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; \
	if ((got) !== (exp)) begin n_mismatch++; \
	$display("mismatch %s exp %h got %h", nm, exp, got); end end
module nsf_host_tb;
	import nsf_pkg::*;
	localparam logic [31:0] SEL = {24'h000000, FEAT_DRIVE};
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic [7:0] dev_status = 8'hE0;
	logic [7:0] io_in, io_out;
	logic avs_waitrequest, chip_sel_low, cmd_latch, addr_latch, write_strobe_low;
	logic read_strobe_low, write_guard_low, io_oe, ready_busy_low;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;

	nsf_host #(.WG_SETTLE(10)) nsf_host_i (.*);
	nsf_dev_model nsf_dev_model_i (.*);

	// Clock and hang guard.
	initial
		forever #5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 50000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic give_verdict;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	// One Avalon-MM transfer, held until waitrequest is seen low.
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge mclk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask : bus

	// Run one device command and collect status and returned bytes.
	task automatic op(input logic [7:0] c, input logic [31:0] adr, input logic [7:0] p,
		output logic [31:0] st, output logic [31:0] rd);
		logic [31:0] q;
		int i;
		bus(1'b1, REG_ADDR, adr, q);
		bus(1'b1, REG_WDATA, {24'h000000, p}, q);
		bus(1'b1, REG_CTRL, 32'h00000100 | {24'h000000, c}, q);
		i = 0;
		do
		begin
			bus(1'b0, REG_STAT, 32'h0, st);
			i++;
		end
		while (i < 2000 && (st[0] !== 1'b0 || (st[1] !== 1'b1 && st[3] !== 1'b1)));
		`CHK("op_finished", 1'b1, i < 2000)
		bus(1'b0, REG_RDATA, 32'h0, rd);
	endtask : op

	task automatic t_guard;
		logic [31:0] q;
		`CHK("guard_after_reset", 1'b0, write_guard_low)
		bus(1'b1, REG_WGUARD, 32'h1, q);
		repeat (15) @(posedge mclk);
		`CHK("guard_released", 1'b1, write_guard_low)
		bus(1'b0, 3'h6, 32'h0, q);
		`CHK("unmapped_read", UNMAPPED_READ, q)
	endtask : t_guard

	task automatic t_status;
		logic [31:0] st, rd;
		logic [7:0] pats [4] = '{8'hE0, 8'h61, 8'h43, 8'h82};
		foreach (pats[i])
		begin
			dev_status <= pats[i];
			op(CMD_STATUS, 32'h0, 8'h00, st, rd);
			`CHK("status_byte", pats[i], st[15:8])
		end
		op(CMD_STATUS_ENH, 32'h00020105, 8'h00, st, rd);
		`CHK("enh_status", pats[3] ^ 8'h02, st[15:8])
	endtask : t_status

	task automatic t_feat;
		logic [31:0] st, rd;
		op(CMD_GET_FEAT, SEL, 8'h00, st, rd);
		`CHK("drive_default", {24'h000000, OUTPUT_DRIVE_SELECT_RST}, rd)
		for (int d = 0; d < 4; d++)
		begin
			op(CMD_SET_FEAT, SEL, 8'(d), st, rd);
			op(CMD_GET_FEAT, SEL, 8'h00, st, rd);
			`CHK("drive_readback", 32'(d), rd)
		end
		op(CMD_RESET, 32'h0, 8'h00, st, rd);
		// The device is still busy with the reset, so enhanced status is refused.
		op(CMD_STATUS_ENH, 32'h00020105, 8'h00, st, rd);
		`CHK("enh_in_reset", 1'b1, st[3])
		op(CMD_GET_FEAT, SEL, 8'h00, st, rd);
		`CHK("drive_after_reset", 32'h00000003, rd)
	endtask : t_feat

	task automatic t_lun;
		logic [31:0] st, rd;
		op(CMD_SET_LUN_FEAT, 32'h00000310, 8'h01, st, rd);
		op(CMD_GET_LUN_FEAT, 32'h00000310, 8'h00, st, rd);
		`CHK("lun3_drive", 32'h00000001, rd)
		op(CMD_GET_LUN_FEAT, 32'h00000010, 8'h00, st, rd);
		`CHK("lun0_drive", 32'h00000003, rd)
	endtask : t_lun

	// Reserved selector, drive above 03h, LUN above 03h and a program command are refused.
	task automatic t_illegal;
		logic [31:0] st, rd;
		logic [31:0] bad [4] = '{SEL | 32'h1, SEL, 32'h00000410, SEL};
		logic [7:0] pv [4] = '{8'h00, 8'h04, 8'h00, 8'h00};
		logic [7:0] cm [4] = '{CMD_SET_FEAT, CMD_SET_FEAT, CMD_SET_LUN_FEAT, 8'h80};
		foreach (bad[i])
		begin
			op(cm[i], bad[i], pv[i], st, rd);
			`CHK("refused", 1'b1, st[3])
		end
	endtask : t_illegal

	// A controller reset in mid-run idles the pins and registers, not the device.
	task automatic t_reset;
		logic [31:0] q, rd;
		srst <= 1'b1;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		`CHK("guard_after_rerun", 1'b0, write_guard_low)
		bus(1'b0, REG_STAT, 32'h0, q);
		`CHK("stat_after_reset", 32'h00000000, q)
		bus(1'b0, REG_WDATA, 32'h0, q);
		`CHK("wdata_after_reset", {24'h000000, OUTPUT_DRIVE_SELECT_RST}, q)
		op(CMD_GET_FEAT, SEL, 8'h00, q, rd);
		`CHK("drive_kept", 32'h00000003, rd)
	endtask : t_reset

	// Main sequence.
	initial
	begin
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		t_guard();
		t_status();
		t_feat();
		t_lun();
		t_illegal();
		t_reset();
		give_verdict();
	end
endmodule : nsf_host_tb
